// ==== core/eecs_pkg.sv ====
package eecs_pkg;
	// ==========================================================
	// Bus geometry and reset source count
	localparam int          ADDR_W       = 4;
	localparam int          DATA_W       = 32;
	localparam int          NUM_RST_SRC  = 4;
	// ==========================================================
	// Register byte offsets
	localparam logic [3:0]  OFS_CTRL     = 4'h0;
	localparam logic [3:0]  OFS_UNLOCK   = 4'h4;
	localparam logic [3:0]  OFS_STATUS   = 4'h8;
	localparam logic [3:0]  OFS_MASK     = 4'hC;
	// ==========================================================
	// Control register fields
	localparam int          CTRL_RSTART  = 0;
	localparam int          CTRL_WSTART  = 1;
	localparam int          CTRL_PERMIT  = 2;
	localparam int          CTRL_ERROR   = 3;
	localparam int          CTRL_W       = 4;
	// ==========================================================
	// Interrupt status / mask fields
	localparam int          EVT_WDONE    = 0;
	localparam int          EVT_WERR     = 1;
	localparam int          EVT_RDONE    = 2;
	localparam int          EVT_W        = 3;
	// ==========================================================
	// Reset source index on the synchroniser
	localparam int          SRC_EXTCLR   = 0;
	localparam int          SRC_WDOG     = 1;
	localparam int          SRC_BROWN    = 2;
	localparam int          SRC_SLEEP    = 3;
	// ==========================================================
	// Unlock key bytes, reset values and bus response codes
	localparam logic [7:0]  UNLOCK_KEY1  = 8'h55;
	localparam logic [7:0]  UNLOCK_KEY2  = 8'hAA;
	localparam logic [3:0]  CTRL_RST     = 4'h0;
	localparam logic [2:0]  EVT_RST      = 3'h0;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// ==== core/eecs_sync_if.sv ====
`timescale 1ns/1ps
interface eecs_sync_if;
	import eecs_pkg::*;
	logic [NUM_RST_SRC-1:0] raw;
	logic [NUM_RST_SRC-1:0] synced;
	modport sync (input raw, output synced);
	modport user (output raw, input synced);
endinterface

// ==== core/eecs_sync.sv ====
`timescale 1ns/1ps
module eecs_sync
	import eecs_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	eecs_sync_if.sync sif
);
	// ==========================================================
	// Two-stage synchroniser, one per pin
	logic [NUM_RST_SRC-1:0] meta_ff;
	logic [NUM_RST_SRC-1:0] hold_ff;
	logic [NUM_RST_SRC-1:0] nxt_meta;
	logic [NUM_RST_SRC-1:0] nxt_hold;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_RST_SRC; gi++) begin : g_bit
			// First stage only feeds the second stage
			always_comb begin
				nxt_meta[gi] = sif.raw[gi];
				nxt_hold[gi] = meta_ff[gi];
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					meta_ff[gi] <= 1'b0;
					hold_ff[gi] <= 1'b0;
				end else begin
					meta_ff[gi] <= nxt_meta[gi];
					hold_ff[gi] <= nxt_hold[gi];
				end
			end
		end
	endgenerate

	assign sif.synced = hold_ff;
endmodule // eecs_sync

// ==== core/eecs_top.sv ====
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// Operation
// (R1) Only control bits 3..0 exist; bits 7..4 read back as zero.
// (R2) Write aborted by external clear, watchdog or brown-out sets error bit 3.
// (R3) Error bit clear means last write finished; software reads and writes it.
// (R4) Permit bit 2 high allows array writes; low blocks every write.
// (R5) Write-start bit 1 launches a write; hardware clears it on completion.
// (R6) Write-start bit reads zero whenever no array write is running.
// (R7) Read-start bit 0 launches a one-cycle read, then hardware clears it.
// (R8) Software can only set the start bits; writing zero does nothing.
// (R9) Permit bit clears at power-up and never by hardware afterwards.
// (R10) Write completion sets the store-done flag; software must clear it.
// (R11) Write-start is refused unless permit was already set beforehand.
// (R12) Software writes 55h then AAh to unlock port before write-start.
// (R13) Writes to the upper unimplemented control bits are ignored.
module eecs_top
	import eecs_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Storage array side
	output logic                   arr_wr_start,
	output logic                   arr_wr_abort,
	output logic                   arr_rd_start,
	input  wire logic              arr_wr_done,
	// Reset sources from pins, active high while asserted
	input  wire logic              external_clear_pin,
	input  wire logic              watchdog_timer_rst,
	input  wire logic              brownout_reset,
	input  wire logic              core_sleep,
	// Interrupt
	output logic                   irq
);
	// ==========================================================
	// Pin synchronisation
	eecs_sync_if sif ();

	assign sif.raw[SRC_EXTCLR] = external_clear_pin;
	assign sif.raw[SRC_WDOG]   = watchdog_timer_rst;
	assign sif.raw[SRC_BROWN]  = brownout_reset;
	assign sif.raw[SRC_SLEEP]  = core_sleep;

	eecs_sync u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sif     (sif)
	);

	// ==========================================================
	// Bus state
	logic              awready_ff, nxt_awready;
	logic              wready_ff,  nxt_wready;
	logic              aw_hold_ff, nxt_aw_hold;
	logic              w_hold_ff,  nxt_w_hold;
	logic [ADDR_W-1:0] awaddr_ff,  nxt_awaddr;
	logic [7:0]        wbyte_ff,   nxt_wbyte;
	logic              wlane_ff,   nxt_wlane;
	logic              bvalid_ff,  nxt_bvalid;
	logic [1:0]        bresp_ff,   nxt_bresp;
	logic              arready_ff, nxt_arready;
	logic              rvalid_ff,  nxt_rvalid;
	logic [DATA_W-1:0] rdata_ff,   nxt_rdata;
	logic [1:0]        rresp_ff,   nxt_rresp;

	// ==========================================================
	// Block state
	logic [CTRL_W-1:0] ctrl_ff,    nxt_ctrl;
	logic              key1_ff,    nxt_key1;
	logic              armed_ff,   nxt_armed;
	logic [EVT_W-1:0]  status_ff,  nxt_status;
	logic [EVT_W-1:0]  mask_ff,    nxt_mask;
	logic              wr_go_ff,   nxt_wr_go;
	logic              wr_abt_ff,  nxt_wr_abt;
	logic              rd_go_ff,   nxt_rd_go;
	logic              irq_ff,     nxt_irq;

	// Decoded strobes shared by both groups
	logic              commit;
	logic              rd_take;
	logic              ctrl_wr, unlock_wr, mask_wr, status_rd;
	logic              abort_src;
	// Events raised this cycle, kept apart from the stored flags so a
	// clearing read that lands on the same edge cannot swallow one
	logic [EVT_W-1:0]  evt;

	// ==========================================================
	// Access decode
	always_comb begin
		commit    = aw_hold_ff && w_hold_ff && !bvalid_ff;
		rd_take   = s_axi_arvalid && arready_ff;
		ctrl_wr   = commit && wlane_ff && (awaddr_ff == OFS_CTRL);
		unlock_wr = commit && wlane_ff && (awaddr_ff == OFS_UNLOCK);
		mask_wr   = commit && wlane_ff && (awaddr_ff == OFS_MASK);
		// Word index only, so the clear matches the read decode
		status_rd = rd_take
		         && (s_axi_araddr[ADDR_W-1:2] == OFS_STATUS[ADDR_W-1:2]);
		// Watchdog only counts as abort outside sleep
		abort_src = sif.synced[SRC_EXTCLR] || sif.synced[SRC_BROWN]
		         || (sif.synced[SRC_WDOG] && !sif.synced[SRC_SLEEP]);
	end

	// ==========================================================
	// AXI4-Lite channel handling: address and data taken in
	// either order, write committed once both are held
	always_comb begin
		nxt_awready = awready_ff;
		nxt_wready  = wready_ff;
		nxt_aw_hold = aw_hold_ff;
		nxt_w_hold  = w_hold_ff;
		nxt_awaddr  = awaddr_ff;
		nxt_wbyte   = wbyte_ff;
		nxt_wlane   = wlane_ff;
		nxt_bvalid  = bvalid_ff;
		nxt_bresp   = bresp_ff;
		nxt_arready = arready_ff;
		nxt_rvalid  = rvalid_ff;
		nxt_rdata   = rdata_ff;
		nxt_rresp   = rresp_ff;
		if (s_axi_awvalid && awready_ff) begin
			nxt_aw_hold = 1'b1;
			nxt_awready = 1'b0;
			nxt_awaddr  = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
		end
		if (s_axi_wvalid && wready_ff) begin
			nxt_w_hold = 1'b1;
			nxt_wready = 1'b0;
			nxt_wbyte  = s_axi_wdata[7:0];
			nxt_wlane  = s_axi_wstrb[0];
		end
		if (commit) begin
			nxt_aw_hold = 1'b0;
			nxt_w_hold  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = RESP_OKAY;
		end
		// Ready is reopened only after the response is taken
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid  = 1'b0;
			nxt_awready = 1'b1;
			nxt_wready  = 1'b1;
		end
		if (rd_take) begin
			nxt_arready = 1'b0;
			nxt_rvalid  = 1'b1;
			nxt_rresp   = RESP_OKAY;
			case (s_axi_araddr[ADDR_W-1:2])
				OFS_CTRL[ADDR_W-1:2]:
					nxt_rdata = {28'h0000000, ctrl_ff}; // [R1] [R6]
				OFS_UNLOCK[ADDR_W-1:2]:
					nxt_rdata = 32'h00000000;
				OFS_STATUS[ADDR_W-1:2]:
					nxt_rdata = {29'h00000000, status_ff};
				OFS_MASK[ADDR_W-1:2]:
					nxt_rdata = {29'h00000000, mask_ff};
				default: begin
					nxt_rdata = 32'h00000000;
					nxt_rresp = RESP_SLVERR;
				end
			endcase
		end
		if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid  = 1'b0;
			nxt_arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			awaddr_ff  <= '0;
			wbyte_ff   <= 8'h00;
			wlane_ff   <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h00000000;
			rresp_ff   <= RESP_OKAY;
		end else begin
			awready_ff <= nxt_awready;
			wready_ff  <= nxt_wready;
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff  <= nxt_w_hold;
			awaddr_ff  <= nxt_awaddr;
			wbyte_ff   <= nxt_wbyte;
			wlane_ff   <= nxt_wlane;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= nxt_bresp;
			arready_ff <= nxt_arready;
			rvalid_ff  <= nxt_rvalid;
			rdata_ff   <= nxt_rdata;
			rresp_ff   <= nxt_rresp;
		end
	end

	// ==========================================================
	// Control bits, unlock sequence, events and interrupt
	always_comb begin
		nxt_ctrl   = ctrl_ff;
		nxt_key1   = key1_ff;
		nxt_armed  = armed_ff;
		nxt_status = status_ff;
		nxt_mask   = mask_ff;
		nxt_wr_go  = 1'b0;
		nxt_wr_abt = 1'b0;
		nxt_rd_go  = 1'b0;
		evt        = {EVT_W{1'b0}};

		// Read strobe lives exactly one cycle
		nxt_ctrl[CTRL_RSTART] = 1'b0; // [R7]
		if (ctrl_ff[CTRL_RSTART])
			evt[EVT_RDONE] = 1'b1; // [R7]

		// Unlock: 55h then AAh, any other byte disarms
		if (unlock_wr) begin
			nxt_key1  = (wbyte_ff == UNLOCK_KEY1) && !key1_ff;
			nxt_armed = key1_ff && (wbyte_ff == UNLOCK_KEY2); // [R12]
		end

		if (ctrl_wr) begin
			// Upper byte bits are dropped
			nxt_ctrl[CTRL_PERMIT] = wbyte_ff[CTRL_PERMIT]; // [R4] [R13]
			nxt_ctrl[CTRL_ERROR]  = wbyte_ff[CTRL_ERROR]; // [R3]
			// Zero writes to start bits are ignored
			if (wbyte_ff[CTRL_RSTART] && !ctrl_ff[CTRL_WSTART]) begin
				nxt_ctrl[CTRL_RSTART] = 1'b1; // [R8]
				nxt_rd_go = 1'b1; // [R7]
			end
			// Old permit value gates the start, not this write's
			if (wbyte_ff[CTRL_WSTART] && ctrl_ff[CTRL_PERMIT]
			    && armed_ff && !ctrl_ff[CTRL_WSTART]) begin
				nxt_ctrl[CTRL_WSTART] = 1'b1; // [R5] [R11] [R8]
				nxt_wr_go = 1'b1; // [R4]
			end
			// Key is used up by any control write
			nxt_armed = 1'b0;
			nxt_key1  = 1'b0;
		end

		// Completion clears the busy bit
		if (ctrl_ff[CTRL_WSTART] && arr_wr_done) begin
			nxt_ctrl[CTRL_WSTART] = 1'b0; // [R5] [R6]
			evt[EVT_WDONE] = 1'b1; // [R10]
		end else if (ctrl_ff[CTRL_WSTART] && abort_src) begin
			// Abort wins over a software clear of the error bit
			nxt_ctrl[CTRL_WSTART] = 1'b0; // [R6]
			nxt_ctrl[CTRL_ERROR]  = 1'b1; // [R2]
			nxt_wr_abt            = 1'b1;
			evt[EVT_WERR]         = 1'b1;
		end

		if (mask_wr)
			nxt_mask = wbyte_ff[EVT_W-1:0];

		// Read-to-clear; an event in the same cycle wins over the clear,
		// even when its flag was already set before the read
		if (status_rd)
			nxt_status = evt; // [R10]
		else
			nxt_status = status_ff | evt; // [R10]
	end

	// Interrupt level from the next status and mask
	always_comb begin
		nxt_irq = |(nxt_status & nxt_mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff   <= CTRL_RST; // [R9]
			key1_ff   <= 1'b0;
			armed_ff  <= 1'b0;
			status_ff <= EVT_RST;
			mask_ff   <= EVT_RST;
			wr_go_ff  <= 1'b0;
			wr_abt_ff <= 1'b0;
			rd_go_ff  <= 1'b0;
			irq_ff    <= 1'b0;
		end else begin
			ctrl_ff   <= nxt_ctrl;
			key1_ff   <= nxt_key1;
			armed_ff  <= nxt_armed;
			status_ff <= nxt_status;
			mask_ff   <= nxt_mask;
			wr_go_ff  <= nxt_wr_go;
			wr_abt_ff <= nxt_wr_abt;
			rd_go_ff  <= nxt_rd_go;
			irq_ff    <= nxt_irq;
		end
	end

	// ==========================================================
	// Outputs, all straight from flip-flops
	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign arr_wr_start  = wr_go_ff;
	assign arr_wr_abort  = wr_abt_ff;
	assign arr_rd_start  = rd_go_ff;
	assign irq           = irq_ff;
endmodule // eecs_top

// ==== verif/eecs_checker.sv ====
`timescale 1ns/1ps
module eecs_checker
	import eecs_pkg::*;
(
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              arr_wr_start,
	input wire logic              arr_wr_abort,
	input wire logic              arr_rd_start,
	input wire logic              arr_wr_done
);
	logic busy_ff;
	logic nxt_busy;

	// ==========================================================
	// Array write in flight, mirrored from the array strobes
	always_comb begin
		nxt_busy = busy_ff;
		if (arr_wr_start)
			nxt_busy = 1'b1;
		if (arr_wr_done || arr_wr_abort)
			nxt_busy = 1'b0;
	end

	// Mirror clears with the block so a mid-run reset stays quiet
	always_ff @(posedge aclk) begin
		if (!aresetn)
			busy_ff <= 1'b0;
		else
			busy_ff <= nxt_busy;
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_wstart_pulse: assert property (
		arr_wr_start |=> !arr_wr_start)
		else $error("write start longer than one cycle");
	chk_wstart_idle: assert property (
		arr_wr_start |-> !busy_ff)
		else $error("write started while one is running");
	chk_abort_busy: assert property (
		arr_wr_abort |-> busy_ff)
		else $error("abort with no write running");
	chk_abort_pulse: assert property (
		arr_wr_abort |=> !arr_wr_abort ##1 !arr_wr_abort)
		else $error("abort pulse repeated");
	chk_rstart_pulse: assert property (
		arr_rd_start |=> !arr_rd_start)
		else $error("read start longer than one cycle");
	chk_rstart_idle: assert property (
		arr_rd_start |-> !busy_ff)
		else $error("read started during a write");
	chk_rdata_upper: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0)
		else $error("unimplemented bits read nonzero");
	chk_r_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=>
			s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped or changed");
	chk_b_okay: assert property (
		s_axi_bvalid |-> s_axi_bresp == RESP_OKAY &&
			!s_axi_awready && !s_axi_wready)
		else $error("write answer wrong or bus reopened");

	// Main scenarios reached
	cov_wr: cover property (arr_wr_start ##[1:20] arr_wr_done);
	cov_ab: cover property (arr_wr_abort);
	cov_rd: cover property (arr_rd_start);
endmodule // eecs_checker

bind eecs_top eecs_checker u_chk (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .arr_wr_start(arr_wr_start),
	.arr_wr_abort(arr_wr_abort), .arr_rd_start(arr_rd_start),
	.arr_wr_done(arr_wr_done)
);

// ==== verif/tb_eeprom_control_status.sv ====
`timescale 1ns/1ps
module tb_eeprom_control_status;
	import eecs_pkg::*;
	logic        aclk, aresetn, awv, wv, brd, arv, rrd, wdn, slp;
	logic        awr, wr_r, bv, arr, rv, ws, wab, rs, irq;
	logic [3:0]  awa, ara, stb;
	logic [31:0] wd, rdt;
	logic [1:0]  bresp, rresp;
	logic [2:0]  src;
	int          bad_count, checks_done;
	int          n_wr = 0, n_rd = 0, n_ab = 0;

	eecs_top dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(stb), .s_axi_wvalid(wv),
		.s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rrd), .arr_wr_start(ws),
		.arr_wr_abort(wab), .arr_rd_start(rs), .arr_wr_done(wdn),
		.external_clear_pin(src[0]), .watchdog_timer_rst(src[1]),
		.brownout_reset(src[2]), .core_sleep(slp), .irq(irq)
	);

	// ==========================================================
	// Clock and strobe counters
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Counted on the falling edge to stay clear of the sampling edge
	always @(negedge aclk) begin
		if (ws === 1'b1) n_wr++;
		if (rs === 1'b1) n_rd++;
		if (wab === 1'b1) n_ab++;
	end

	// ==========================================================
	// Report and bus tasks
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic hang();
		bad_count++;
		$display("ERROR bus wait expected answer seen none");
		final_report();
	endtask

	task automatic axi_wr(input logic [3:0] a, input logic [7:0] d);
		int i;
		awa <= a;
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		brd <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wr_r) wv <= 1'b0;
			if (bv) break;
		end
		brd <= 1'b0;
		// One idle edge so the next call never re-drives in this step
		@(posedge aclk);
		if (i == 50) hang();
	endtask

	task automatic chk_rd(input string nm, input logic [3:0] a,
			input logic [31:0] e);
		int i;
		ara <= a;
		arv <= 1'b1;
		rrd <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		rrd <= 1'b0;
		@(posedge aclk);
		cmp(nm, e, rdt);
		cmp("rresp", {30'h0, RESP_OKAY}, {30'h0, rresp});
		if (i == 50) hang();
	endtask

	// Unlock pair then control write; any control write disarms
	task automatic go(input logic [7:0] c);
		axi_wr(OFS_UNLOCK, UNLOCK_KEY1);
		axi_wr(OFS_UNLOCK, UNLOCK_KEY2);
		axi_wr(OFS_CTRL, c);
		repeat (2) @(posedge aclk);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk_rd("ctrl", OFS_CTRL, 32'h0);
		chk_rd("unlock", OFS_UNLOCK, 32'h0);
		chk_rd("status", OFS_STATUS, 32'h0);
		chk_rd("mask", OFS_MASK, 32'h0);
	endtask

	task automatic t_refuse();
		go(8'h06);
		chk_rd("ctrl", OFS_CTRL, 32'h4);
		cmp("starts", 32'h0, 32'(n_wr));
		axi_wr(OFS_CTRL, 8'hF4);
		chk_rd("ctrl", OFS_CTRL, 32'h4);
		// Byte lane 0 switched off: the whole write must be dropped
		stb <= 4'h0;
		axi_wr(OFS_CTRL, 8'h00);
		stb <= 4'h1;
		chk_rd("ctrl", OFS_CTRL, 32'h4);
		axi_wr(OFS_CTRL, 8'h06);
		repeat (2) @(posedge aclk);
		chk_rd("ctrl", OFS_CTRL, 32'h4);
		cmp("starts", 32'h0, 32'(n_wr));
	endtask

	task automatic t_write();
		axi_wr(OFS_MASK, 8'h07);
		go(8'h06);
		cmp("starts", 32'h1, 32'(n_wr));
		axi_wr(OFS_CTRL, 8'h04);
		chk_rd("ctrl", OFS_CTRL, 32'h6);
		cmp("irq", 32'h0, {31'h0, irq});
		wdn <= 1'b1;
		@(posedge aclk);
		wdn <= 1'b0;
		repeat (2) @(posedge aclk);
		chk_rd("ctrl", OFS_CTRL, 32'h4);
		cmp("irq", 32'h1, {31'h0, irq});
		chk_rd("status", OFS_STATUS, 32'h1);
		chk_rd("status", OFS_STATUS, 32'h0);
		repeat (2) @(posedge aclk);
		cmp("irq", 32'h0, {31'h0, irq});
	endtask

	// Each of external clear, watchdog and brown-out in turn cuts a running write short
	task automatic t_abort();
		int s;
		for (s = 0; s < 3; s++) begin
			go(8'h06);
			src[s] <= 1'b1;
			repeat (4) @(posedge aclk);
			src[s] <= 1'b0;
			repeat (4) @(posedge aclk);
			cmp("aborts", 32'(s + 1), 32'(n_ab));
			chk_rd("ctrl", OFS_CTRL, 32'hC);
			chk_rd("status", OFS_STATUS, 32'h2);
			axi_wr(OFS_CTRL, 8'h04);
			chk_rd("ctrl", OFS_CTRL, 32'h4);
		end
		cmp("starts", 32'h4, 32'(n_wr));
		// Watchdog while asleep is no abort; the write ends normally
		slp <= 1'b1;
		go(8'h06);
		src[1] <= 1'b1;
		repeat (4) @(posedge aclk);
		src[1] <= 1'b0;
		repeat (4) @(posedge aclk);
		slp <= 1'b0;
		cmp("aborts", 32'h3, 32'(n_ab));
		chk_rd("ctrl", OFS_CTRL, 32'h6);
		wdn <= 1'b1;
		@(posedge aclk);
		wdn <= 1'b0;
		repeat (2) @(posedge aclk);
		chk_rd("ctrl", OFS_CTRL, 32'h4);
		chk_rd("status", OFS_STATUS, 32'h1);
		cmp("starts", 32'h5, 32'(n_wr));
	endtask

	task automatic t_read();
		axi_wr(OFS_MASK, 8'h00);
		axi_wr(OFS_CTRL, 8'h05);
		repeat (2) @(posedge aclk);
		cmp("reads", 32'h1, 32'(n_rd));
		chk_rd("ctrl", OFS_CTRL, 32'h4);
		cmp("irq", 32'h0, {31'h0, irq});
		axi_wr(OFS_MASK, 8'h04);
		repeat (2) @(posedge aclk);
		cmp("irq", 32'h1, {31'h0, irq});
		chk_rd("status", OFS_STATUS, 32'h4);
		repeat (2) @(posedge aclk);
		cmp("irq", 32'h0, {31'h0, irq});
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{aresetn, awv, wv, brd, arv, rrd, wdn, slp, src} = '0;
		stb = 4'h1;
		awa = 4'h0;
		ara = 4'h0;
		wd = 32'h0;
		bad_count = 0;
		checks_done = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_refuse();
		t_write();
		t_abort();
		t_read();
		final_report();
	end
endmodule // tb_eeprom_control_status
